// *** hw/dcr_bus_sense.sv ***
// Synchroniser and condition detector for the two serial bus pins
`timescale 1ns/100ps
`default_nettype none

module dcr_bus_sense (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Raw pins
    input  wire logic sclPin,
    input  wire logic sdaPin,
    // Detected events, one-cycle pulses
    output logic      sclRise,
    output logic      sclFall,
    output logic      startSeen,
    output logic      stopSeen,
    // Settled data level
    output logic      sdaLevel
);
    logic [1:0] sclMeta_r;   // First stage then second stage
    logic [1:0] sdaMeta_r;
    logic       sclPrev_r;   // Third stage for edge finding
    logic       sdaPrev_r;

    // Two-flop synchronisers; stage 0 is read only by stage 1
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclMeta_r <= 2'h3;
            sdaMeta_r <= 2'h3;
        end else begin
            sclMeta_r <= {sclMeta_r[0], sclPin};
            sdaMeta_r <= {sdaMeta_r[0], sdaPin};
        end
    end

    // History for edge and condition detection
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
        end else begin
            sclPrev_r <= sclMeta_r[1];
            sdaPrev_r <= sdaMeta_r[1];
        end
    end

    // Clock edges found by the system clock
    assign sclRise   = sclMeta_r[1] & ~sclPrev_r;
    assign sclFall   = ~sclMeta_r[1] & sclPrev_r;
    // Data moving while clock high marks start or stop
    assign startSeen = sclMeta_r[1] & sclPrev_r & sdaPrev_r & ~sdaMeta_r[1];
    assign stopSeen  = sclMeta_r[1] & sclPrev_r & ~sdaPrev_r & sdaMeta_r[1];
    assign sdaLevel  = sdaMeta_r[1];

endmodule

`default_nettype wire

// *** hw/dcr_config_bank.sv ***
// Configuration and code register bank behind a serial slave port
// Behaviour
// - Reference code 0x supply, 10 pin, 11 buffered
// - Power code 00 normal, others select loads
// - Powered down: circuits off, amplifier disconnected
// - Gain bit 0 unity, 1 doubles
// - Supply reference forces unity gain
// - Power-on loads volatile from nonvolatile copies
// - Brown-out: power field 11, rest cleared
// - Code width 12/10/8, right-aligned, upper absent
// - Slave only, never drives clock
// - Works at standard, fast, high-speed rates
// - First byte after start is address
// - Data sampled on clock rising edge
// - Data change with clock high: start/stop
// - Never stretches the serial clock
`timescale 1ns/100ps
`default_nettype none

module dcr_config_bank #(
    parameter int              CODE_W   = 12,      // Implemented code bits
    parameter logic [2:0]      ADDR_LOW = 3'h0     // User address bits
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst,
    // Serial bus pins; clock is input only
    input  wire logic                        sclPin,
    input  wire logic                        sdaIn,
    output logic                             sdaOut,
    output logic                             sdaOe,
    // Supply events, one-cycle pulses on mclk
    input  wire logic                        powerOnEvent,
    input  wire logic                        brownOutEvent,
    // Nonvolatile copies
    input  wire dcr_pkg::dcr_cfg_t           nvConfig,
    input  wire logic [dcr_pkg::DCR_CODE_FIELD_W-1:0] nvCode,
    // Volatile state to the analog side
    output dcr_pkg::dcr_cfg_t                configOut,
    output logic [dcr_pkg::DCR_CODE_FIELD_W-1:0] codeOut,
    output dcr_pkg::dcr_analog_t             analogCtrl,
    // Write completed, one-cycle pulse
    output logic                             writeDone
);
    import dcr_pkg::*;

    // Widths the code register can take
    if (CODE_W != 8 && CODE_W != 10 && CODE_W != 12) begin : gChk
        $error("CODE_W must be 8, 10 or 12");
    end

    // Frame engine states
    typedef enum logic [2:0] {
        DCR_IDLE, DCR_ADDR, DCR_ADDR_ACK, DCR_WR_BYTE, DCR_WR_ACK,
        DCR_RD_BYTE, DCR_RD_ACK, DCR_IGNORE
    } dcr_state_t;

    dcr_state_t           state_r;        // Frame engine state
    logic [7:0]           rxShift_r;      // Incoming byte
    logic [7:0]           txShift_r;      // Outgoing byte
    logic [7:0]           readNow;        // Byte the read path sends next
    logic [3:0]           bitCnt_r;       // Bits of current byte
    logic [1:0]           byteIdx_r;      // Position within frame
    logic                 readMode_r;     // Direction bit of address
    logic                 ackOe_r;        // Pull data low
    logic                 masterAck_r;    // Master acknowledged read byte
    dcr_cfg_t             cfgStage_r;     // Staged config byte
    logic [3:0]           codeHiStage_r;  // Staged code high bits
    dcr_cfg_t             cfg_r;          // Volatile config
    logic [CODE_W-1:0]    code_r;         // Volatile code, implemented bits only
    logic                 commit_r;       // Write commit pulse
    logic [11:0]          commitCode;     // Staged full code field
    logic                 sclRise;
    logic                 sclFall;
    logic                 startSeen;
    logic                 stopSeen;
    logic                 sdaLevel;

    // Pin sensing; detector sees rates up to high-speed at 20 MHz
    dcr_bus_sense uSense (
        .mclk      (mclk),
        .rst       (rst),
        .sclPin    (sclPin),
        .sdaPin    (sdaIn),
        .sclRise   (sclRise),
        .sclFall   (sclFall),
        .startSeen (startSeen),
        .stopSeen  (stopSeen),
        .sdaLevel  (sdaLevel)
    );

    // Byte returned for a frame position
    function automatic logic [7:0] readByte(input logic [1:0] idx, input dcr_cfg_t c,
                                            input logic [11:0] code);
        case (idx)
            DCR_IDX_CFG:     readByte = {3'h0, c};
            DCR_IDX_CODE_HI: readByte = {4'h0, code[11:8]};
            DCR_IDX_CODE_LO: readByte = code[7:0];
            default:         readByte = 8'hff;
        endcase
    endfunction
    assign readNow = readByte(byteIdx_r, cfg_r, codeOut);  // Selected by frame position
    // Address match on fixed code and user bits
    function automatic logic addrMatch(input logic [7:0] b);
        addrMatch = (b[7:4] == DCR_FIXED_CODE) && (b[3:1] == ADDR_LOW);
    endfunction

    // Frame engine; start and stop from the master take priority over clock edges
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r     <= DCR_IDLE;
            bitCnt_r    <= 4'h0;
            byteIdx_r   <= 2'h0;
            readMode_r  <= 1'b0;
            ackOe_r     <= 1'b0;
            masterAck_r <= 1'b0;
        end else if (startSeen) begin
            // Start or repeated start begins address byte
            state_r   <= DCR_ADDR;
            bitCnt_r  <= 4'h0;
            byteIdx_r <= 2'h0;
            ackOe_r   <= 1'b0;
        end else if (stopSeen) begin
            // Stop ends the frame and frees the line
            state_r <= DCR_IDLE;
            ackOe_r <= 1'b0;
        end else if (sclRise) begin
            // Receive sampling on rising clock
            case (state_r)
                DCR_ADDR, DCR_WR_BYTE: begin
                    bitCnt_r <= bitCnt_r + 4'h1;
                end
                DCR_RD_ACK: begin
                    masterAck_r <= ~sdaLevel;
                end
                default: begin
                end
            endcase
        end else if (sclFall) begin
            case (state_r)
                DCR_ADDR: begin
                    // First byte is the slave address
                    if (bitCnt_r == DCR_BIT_LAST && addrMatch(rxShift_r)) begin
                        readMode_r <= rxShift_r[0];
                        ackOe_r    <= 1'b1;
                        state_r    <= DCR_ADDR_ACK;
                    end else if (bitCnt_r == DCR_BIT_LAST) begin
                        state_r <= DCR_IGNORE;
                    end
                end
                DCR_ADDR_ACK: begin
                    bitCnt_r <= 4'h0;
                    if (readMode_r) begin
                        ackOe_r  <= ~readNow[7];
                        bitCnt_r <= 4'h1;
                        state_r  <= DCR_RD_BYTE;
                    end else begin
                        ackOe_r <= 1'b0;
                        state_r <= DCR_WR_BYTE;
                    end
                end
                DCR_WR_BYTE: begin
                    // Acknowledge bytes within the frame, refuse extras
                    if (bitCnt_r == DCR_BIT_LAST && byteIdx_r != DCR_IDX_OVER) begin
                        ackOe_r <= 1'b1;
                        state_r <= DCR_WR_ACK;
                    end else if (bitCnt_r == DCR_BIT_LAST) begin
                        state_r <= DCR_IGNORE;
                    end
                end
                DCR_WR_ACK: begin
                    ackOe_r   <= 1'b0;
                    bitCnt_r  <= 4'h0;
                    byteIdx_r <= byteIdx_r + 2'h1;
                    state_r   <= DCR_WR_BYTE;
                end
                DCR_RD_BYTE: begin
                    // Data changed only while clock is low
                    if (bitCnt_r == DCR_BIT_LAST) begin
                        ackOe_r   <= 1'b0;
                        byteIdx_r <= (byteIdx_r == DCR_IDX_CODE_LO) ? DCR_IDX_CFG : byteIdx_r + 2'h1;
                        state_r   <= DCR_RD_ACK;
                    end else begin
                        ackOe_r  <= ~txShift_r[7];
                        bitCnt_r <= bitCnt_r + 4'h1;
                    end
                end
                DCR_RD_ACK: begin
                    // Master ack asks for next byte, nack ends reading
                    if (masterAck_r) begin
                        ackOe_r  <= ~readNow[7];
                        bitCnt_r <= 4'h1;
                        state_r  <= DCR_RD_BYTE;
                    end else begin
                        state_r <= DCR_IGNORE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Receive shifter, rising clock edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxShift_r <= 8'h00;
        end else if (sclRise && (state_r == DCR_ADDR || state_r == DCR_WR_BYTE)) begin
            rxShift_r <= {rxShift_r[6:0], sdaLevel};
        end
    end

    // Transmit shifter; loaded when a read byte starts, shifted per bit
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            txShift_r <= 8'h00;
        end else if (sclFall && (state_r == DCR_ADDR_ACK || state_r == DCR_RD_ACK)) begin
            txShift_r <= {readNow[6:0], 1'b0};
        end else if (sclFall && state_r == DCR_RD_BYTE && bitCnt_r != DCR_BIT_LAST) begin
            txShift_r <= {txShift_r[6:0], 1'b0};
        end
    end

    // Staging of written bytes; last byte commits the frame
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfgStage_r    <= DCR_CFG_RESET;
            codeHiStage_r <= 4'h0;
            commit_r      <= 1'b0;
        end else begin
            commit_r <= 1'b0;
            if (sclFall && state_r == DCR_WR_BYTE && bitCnt_r == DCR_BIT_LAST) begin
                case (byteIdx_r)
                    DCR_IDX_CFG:     cfgStage_r    <= dcr_cfg_t'(rxShift_r[DCR_CFG_W-1:0]);
                    DCR_IDX_CODE_HI: codeHiStage_r <= rxShift_r[3:0];
                    DCR_IDX_CODE_LO: commit_r      <= 1'b1;
                    default: begin
                    end
                endcase
            end
        end
    end

    assign commitCode = {codeHiStage_r, rxShift_r};
    // Volatile registers; brown-out over power-on over bus write
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_r  <= DCR_CFG_RESET;
            code_r <= DCR_CODE_RESET[CODE_W-1:0];
        end else if (brownOutEvent) begin
            cfg_r  <= DCR_CFG_BROWNOUT;
            code_r <= DCR_CODE_RESET[CODE_W-1:0];
        end else if (powerOnEvent) begin
            cfg_r  <= nvConfig;
            code_r <= nvCode[CODE_W-1:0];
        end else if (commit_r) begin
            cfg_r  <= cfgStage_r;
            code_r <= commitCode[CODE_W-1:0];
        end
    end

    // Completion flag for the user side
    assign writeDone = commit_r;

    // Open-drain data: only pulls low, clock never driven
    assign sdaOut    = 1'b0;
    assign sdaOe     = ackOe_r;

    // Volatile state out, absent upper bits read zero
    assign configOut = cfg_r;
    assign codeOut   = DCR_CODE_FIELD_W'(code_r);

    // Reference decode
    assign analogCtrl.refFromSupply = ~cfg_r.ladderRefSelect[1];
    assign analogCtrl.refFromPin    = cfg_r.ladderRefSelect[1];
    assign analogCtrl.refBuffered   = (cfg_r.ladderRefSelect == DCR_REF_EXT_BUF);
    // Power-down decode
    assign analogCtrl.ampConnected  = (cfg_r.powerdownSelect == DCR_PWR_NORMAL);
    assign analogCtrl.circuitsOn    = (cfg_r.powerdownSelect == DCR_PWR_NORMAL);
    assign analogCtrl.loadSelect    = {cfg_r.powerdownSelect == DCR_PWR_LOAD_HI,
                                       cfg_r.powerdownSelect == DCR_PWR_LOAD_MID,
                                       cfg_r.powerdownSelect == DCR_PWR_LOAD_LO};
    // Gain, forced to unity on supply reference
    assign analogCtrl.gainTwo       = cfg_r.gainSelect & cfg_r.ladderRefSelect[1];

endmodule

`default_nettype wire

// *** hw/dcr_pkg.sv ***
// Shared constants and types for the converter configuration register bank
package dcr_pkg;

    // Slave address byte layout
    localparam logic [3:0] DCR_FIXED_CODE  = 4'hc;   // Upper four address bits, fixed
    localparam int         DCR_ADDR_LOW_W  = 3;      // User address bits
    localparam int         DCR_BYTE_W      = 8;      // Bits per bus byte
    localparam logic [3:0] DCR_BIT_LAST    = 4'h8;   // Bit count at end of a byte

    // Frame layout: config byte, code high byte, code low byte
    localparam logic [1:0] DCR_IDX_CFG     = 2'h0;
    localparam logic [1:0] DCR_IDX_CODE_HI = 2'h1;
    localparam logic [1:0] DCR_IDX_CODE_LO = 2'h2;
    localparam logic [1:0] DCR_IDX_OVER    = 2'h3;   // Bytes beyond the frame

    // Field widths and positions inside the config byte
    localparam int         DCR_CFG_W       = 5;
    localparam int         DCR_CODE_FIELD_W = 12;    // Right-aligned code field
    localparam int         DCR_POS_GAIN    = 0;
    localparam int         DCR_POS_PWR     = 1;      // Two bits
    localparam int         DCR_POS_REF     = 3;      // Two bits

    // Ladder reference select codes
    localparam logic [1:0] DCR_REF_EXT_UNBUF = 2'b10;
    localparam logic [1:0] DCR_REF_EXT_BUF   = 2'b11;

    // Power-down select codes
    localparam logic [1:0] DCR_PWR_NORMAL  = 2'b00;
    localparam logic [1:0] DCR_PWR_LOAD_LO = 2'b01;
    localparam logic [1:0] DCR_PWR_LOAD_MID = 2'b10;
    localparam logic [1:0] DCR_PWR_LOAD_HI = 2'b11;
    localparam logic [1:0] DCR_PWR_BROWNOUT = 2'b11;

    // Reset and brown-out values
    localparam logic       DCR_GAIN_RESET  = 1'b0;
    localparam logic [1:0] DCR_REF_RESET   = 2'b00;
    localparam logic [11:0] DCR_CODE_RESET = 12'h000;

    // Volatile configuration fields
    typedef struct packed {
        logic [1:0] ladderRefSelect;  // Ladder reference source
        logic [1:0] powerdownSelect;  // Output state and load
        logic       gainSelect;       // Output gain
    } dcr_cfg_t;

    // Decoded analog control bundle
    typedef struct packed {
        logic       refFromSupply;    // Supply feeds ladder, unbuffered
        logic       refFromPin;       // Reference pin feeds ladder
        logic       refBuffered;      // Reference pin through buffer
        logic       ampConnected;     // Amplifier drives output pin
        logic       circuitsOn;       // Internal circuits powered
        logic [2:0] loadSelect;       // One-hot load: lo, mid, hi resistance
        logic       gainTwo;          // Gain of two in effect
    } dcr_analog_t;

    localparam dcr_cfg_t DCR_CFG_RESET = '{DCR_REF_RESET, DCR_PWR_NORMAL, DCR_GAIN_RESET};
    localparam dcr_cfg_t DCR_CFG_BROWNOUT = '{DCR_REF_RESET, DCR_PWR_BROWNOUT, DCR_GAIN_RESET};

endpackage

// *** test/dcr_bus_master.sv ***
// Serial bus master model: makes the clock, start and stop, open-drain data
`timescale 1ns/100ps
`default_nettype none

module dcr_bus_master (
    // Clock
    input  wire logic mclk,
    // Bus lines
    input  wire logic sdaLine,
    output logic      sclPin,
    output logic      sdaLow
);
    int halfCycles = 4;  // Clock half period in mclk cycles

    // Idle bus: clock stands high, data released
    initial begin
        sclPin = 1'b1;
        sdaLow = 1'b0;
    end

    task automatic waitHalf;
        repeat (halfCycles) @(posedge mclk);
    endtask

    // Start or repeated start: data falls while clock high
    task automatic startBit;
        @(posedge mclk);
        sdaLow <= 1'b0;
        waitHalf();
        sclPin <= 1'b1;
        waitHalf();
        sdaLow <= 1'b1;
        waitHalf();
        sclPin <= 1'b0;
    endtask

    // Stop: data rises while clock high
    task automatic stopBit;
        @(posedge mclk);
        sdaLow <= 1'b1;
        waitHalf();
        sclPin <= 1'b1;
        waitHalf();
        sdaLow <= 1'b0;
        waitHalf();
    endtask

    // One bit: data moves only with clock low, sampled at end of high
    task automatic xfer(input logic b, output logic s);
        @(posedge mclk);
        sdaLow <= ~b;
        waitHalf();
        sclPin <= 1'b1;
        waitHalf();
        s = sdaLine;
        sclPin <= 1'b0;
    endtask

    // Byte out, MSB first, then the receiver's acknowledge
    task automatic writeByte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(d[i], s);
        xfer(1'b1, s);
        ack = ~s;
    endtask

    // Byte in, then acknowledge or not
    task automatic readByte(output logic [7:0] d, input logic ackIt);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(1'b1, d[i]);
        xfer(~ackIt, s);
    endtask
endmodule
`default_nettype wire

// *** test/dcr_config_bank_assertions.sv ***
// Checker for decode, supply events and commits of the register bank
`timescale 1ns/100ps
`default_nettype none

module dcr_config_bank_assertions import dcr_pkg::*; #(
    parameter int CODE_W = 12  // Implemented code bits
) (
    // Clock and reset
    input wire logic                                  mclk,
    input wire logic                                  rst,
    // Bus pins
    input wire logic                                  sclPin,
    input wire logic                                  sdaIn,
    input wire logic                                  sdaOut,
    input wire logic                                  sdaOe,
    // Supply events and nonvolatile copies
    input wire logic                                  powerOnEvent,
    input wire logic                                  brownOutEvent,
    input wire dcr_pkg::dcr_cfg_t                     nvConfig,
    input wire logic [dcr_pkg::DCR_CODE_FIELD_W-1:0]  nvCode,
    // Volatile state
    input wire dcr_pkg::dcr_cfg_t                     configOut,
    input wire logic [dcr_pkg::DCR_CODE_FIELD_W-1:0]  codeOut,
    input wire dcr_pkg::dcr_analog_t                  analogCtrl,
    input wire logic                                  writeDone
);
    // Bits that the variant really stores
    localparam logic [11:0] CODE_MASK = 12'hfff >> (12 - CODE_W);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Supply event steps: cause, then the state one cycle on
    sequence boCause; brownOutEvent; endsequence
    sequence boState; configOut == DCR_CFG_BROWNOUT && codeOut == 12'h000; endsequence
    sequence poCause; powerOnEvent && !brownOutEvent; endsequence
    sequence poState; configOut == $past(nvConfig) && codeOut == ($past(nvCode) & CODE_MASK); endsequence

    AST_REF_DECODE: assert property (analogCtrl.refFromSupply == !configOut.ladderRefSelect[1]
        && analogCtrl.refFromPin == configOut.ladderRefSelect[1]
        && analogCtrl.refBuffered == (configOut.ladderRefSelect == DCR_REF_EXT_BUF))
        else $error("Reference decode does not follow the select field");
    AST_PWR_OFF: assert property (analogCtrl.circuitsOn == (configOut.powerdownSelect == DCR_PWR_NORMAL)
        && analogCtrl.ampConnected == (configOut.powerdownSelect == DCR_PWR_NORMAL))
        else $error("Circuit or amplifier state does not follow power-down field");
    AST_LOAD: assert property (analogCtrl.loadSelect == {configOut.powerdownSelect == DCR_PWR_LOAD_HI,
        configOut.powerdownSelect == DCR_PWR_LOAD_MID, configOut.powerdownSelect == DCR_PWR_LOAD_LO})
        else $error("Load select does not follow power-down field");
    AST_GAIN: assert property (analogCtrl.gainTwo == (configOut.gainSelect && configOut.ladderRefSelect[1]))
        else $error("Gain decode wrong");
    AST_BROWNOUT: assert property (boCause |=> boState)
        else $error("Brown-out state not forced");
    AST_POWERON: assert property (poCause |=> poState)
        else $error("Power-on did not load nonvolatile copies");
    AST_CODE_WIDTH: assert property ((codeOut & ~CODE_MASK) == 12'h000)
        else $error("Unimplemented code bits not zero");
    AST_ONLY_ON_CAUSE: assert property (($changed(codeOut) || $changed(configOut))
        |-> ($past(writeDone) || $past(powerOnEvent) || $past(brownOutEvent)))
        else $error("Registers changed without a commit or supply event");
    AST_DONE_PULSE: assert property (writeDone |=> !writeDone)
        else $error("Write done longer than one cycle");
    AST_OPEN_DRAIN: assert property (sdaOut == 1'b0)
        else $error("Data pin drive value not low");
endmodule

bind dcr_config_bank dcr_config_bank_assertions #(.CODE_W(CODE_W)) dcr_config_bank_assertions_i (
    .mclk(mclk), .rst(rst), .sclPin(sclPin), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .powerOnEvent(powerOnEvent), .brownOutEvent(brownOutEvent), .nvConfig(nvConfig), .nvCode(nvCode),
    .configOut(configOut), .codeOut(codeOut), .analogCtrl(analogCtrl), .writeDone(writeDone));
`default_nettype wire

// *** test/dcr_config_bank_tb.sv ***
// Testbench for the configuration register bank behind its serial port
`timescale 1ns/100ps
`default_nettype none

module dcr_config_bank_tb;
    import dcr_pkg::*;
    localparam int         CODE_W   = 10;    // Ten-bit variant
    localparam logic [2:0] ADDR_LOW = 3'h5;  // User address bits
    localparam logic [6:0] DEV      = {DCR_FIXED_CODE, ADDR_LOW};

    // Table row: frame contents beside expected outputs
    typedef struct packed {
        dcr_cfg_t    cfg;
        logic [11:0] code;
        logic [11:0] expCode;
        dcr_analog_t expAna;
        logic        slow;
    } dcr_row_t;
    localparam dcr_row_t ROWS [0:5] = '{
        '{5'h01, 12'hfff, 12'h3ff, 9'h130, 1'b0}, '{5'h0a, 12'h000, 12'h000, 9'h102, 1'b0},
        '{5'h15, 12'ha5c, 12'h25c, 9'h085, 1'b1}, '{5'h1f, 12'h123, 12'h123, 9'h0c9, 1'b0},
        '{5'h18, 12'h800, 12'h000, 9'h0f0, 1'b0}, '{5'h11, 12'h001, 12'h001, 9'h0b1, 1'b0}};

    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        powerOnEvent = 1'b0;
    logic        brownOutEvent = 1'b0;
    dcr_cfg_t    nvConfig = 5'h00;
    logic [11:0] nvCode = 12'h000;
    logic        sclPin;         // Clock from the master model
    logic        mstLow;         // Master pulls data low
    wire logic   sdaLine;        // Data wire with pull-up
    logic        sdaOut;
    logic        sdaOe;
    dcr_cfg_t    configOut;
    logic [11:0] codeOut;
    dcr_analog_t analogCtrl;
    logic        writeDone;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    int          nAck;
    logic [7:0]  r0, r1, r2;

    // Open-drain wire: any party pulling low wins
    assign sdaLine = (mstLow || (sdaOe && !sdaOut)) ? 1'b0 : 1'b1;

    always #25 mclk = ~mclk;

    dcr_config_bank #(.CODE_W(CODE_W), .ADDR_LOW(ADDR_LOW)) dcr_config_bank_i (
        .mclk(mclk), .rst(rst), .sclPin(sclPin), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .powerOnEvent(powerOnEvent), .brownOutEvent(brownOutEvent), .nvConfig(nvConfig), .nvCode(nvCode),
        .configOut(configOut), .codeOut(codeOut), .analogCtrl(analogCtrl), .writeDone(writeDone));

    dcr_bus_master dcr_bus_master_i (.mclk(mclk), .sdaLine(sdaLine), .sclPin(sclPin), .sdaLow(mstLow));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask

    // Write bytes after a start, counting acknowledges; stop is optional
    task automatic sendBytes(input logic [7:0] q [$], input logic doStop, output int n);
        logic a;
        n = 0;
        dcr_bus_master_i.startBit();
        foreach (q[i]) begin
            dcr_bus_master_i.writeByte(q[i], a);
            n += int'(a);
        end
        if (doStop) dcr_bus_master_i.stopBit();
    endtask

    // Read three bytes, nack on the last
    task automatic rdFrame(output logic [7:0] b0, output logic [7:0] b1, output logic [7:0] b2);
        logic a;
        dcr_bus_master_i.startBit();
        dcr_bus_master_i.writeByte({DEV, 1'b1}, a);
        chk("read address ack", 16'h1, {15'h0, a});
        dcr_bus_master_i.readByte(b0, 1'b1);
        dcr_bus_master_i.readByte(b1, 1'b1);
        dcr_bus_master_i.readByte(b2, 1'b0);
        dcr_bus_master_i.stopBit();
    endtask

    task automatic pulse(input logic po, input logic bo);
        @(posedge mclk);
        powerOnEvent <= po;
        brownOutEvent <= bo;
        @(posedge mclk);
        powerOnEvent <= 1'b0;
        brownOutEvent <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic tally_and_finish;
        $display("Counts: checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("reset config", 16'h0, {11'h0, configOut});
        chk("reset code", 16'h0, {4'h0, codeOut});
        // Table rows: write, compare decode, read back
        foreach (ROWS[i]) begin
            dcr_bus_master_i.halfCycles = ROWS[i].slow ? 50 : 4;
            sendBytes('{{DEV, 1'b0}, {3'h0, ROWS[i].cfg}, {4'h0, ROWS[i].code[11:8]}, ROWS[i].code[7:0]}, 1'b1, nAck);
            chk("write acks", 16'h4, nAck[15:0]);
            chk("config", {11'h0, ROWS[i].cfg}, {11'h0, configOut});
            chk("code", {4'h0, ROWS[i].expCode}, {4'h0, codeOut});
            chk("analog", {7'h0, ROWS[i].expAna}, {7'h0, analogCtrl});
            rdFrame(r0, r1, r2);
            chk("read config", {8'h0, 3'h0, ROWS[i].cfg}, {8'h0, r0});
            chk("read code", {4'h0, ROWS[i].expCode}, {r1, r2});
        end
        dcr_bus_master_i.halfCycles = 4;
        // Other address: no ack, nothing stored
        sendBytes('{{DEV ^ 7'h01, 1'b0}, 8'h1f, 8'h0f, 8'hff}, 1'b1, nAck);
        chk("foreign acks", 16'h0, nAck[15:0]);
        // Frame cut short by a repeated start, then a whole frame
        sendBytes('{{DEV, 1'b0}, 8'h0a, 8'h03}, 1'b0, nAck);
        chk("aborted config", 16'h11, {11'h0, configOut});
        sendBytes('{{DEV, 1'b0}, 8'h0a, 8'h03, 8'h45}, 1'b1, nAck);
        chk("after restart code", 16'h345, {4'h0, codeOut});
        // Byte beyond the frame is refused
        sendBytes('{{DEV, 1'b0}, 8'h18, 8'h0f, 8'hff, 8'h00}, 1'b1, nAck);
        chk("extra byte acks", 16'h4, nAck[15:0]);
        chk("extra byte code", 16'h3ff, {4'h0, codeOut});
        // Supply events
        nvConfig <= 5'h15;
        nvCode <= 12'hc3a;
        pulse(1'b1, 1'b0);
        chk("power-on config", 16'h15, {11'h0, configOut});
        chk("power-on code", 16'h03a, {4'h0, codeOut});
        pulse(1'b1, 1'b1);
        chk("brown-out config", 16'h06, {11'h0, configOut});
        chk("brown-out code", 16'h0, {4'h0, codeOut});
        // Reset in mid-run clears the bank
        sendBytes('{{DEV, 1'b0}, 8'h1f, 8'h01, 8'h23}, 1'b1, nAck);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("second reset config", 16'h0, {11'h0, configOut});
        tally_and_finish();
    end
endmodule
`default_nettype wire
